// File: verilog/smbus_pkg.sv
// Constants and state encoding for the management bus slave with register pointer
//
// Overview of operation
// - Respond only to fixed seven-bit slave address 2E; nothing configurable.
// - First byte after start is address plus direction bit; 5C when writing.
// - Each byte is nine clocks: eight data bits MSB first, then acknowledge, given by the master on the read byte.
// - Data changes only while clock low; rising data with clock high is stop.
// - Direction is fixed by the address byte; switching needs a new operation.
// - Accept one or two write bytes; supply exactly one byte on a read.
// - First write byte always loads the register pointer, never a data register.
// - A second write byte is stored into the register the pointer selects.
// - Read returns the pointed register without rewriting the pointer first.
// - Single-byte write only sets the pointer and modifies no data register.
// - Support send byte, receive byte, read byte and write byte formats.
// - Repeated start is accepted as the beginning of a new operation.
// - Slave only; never initiates a transfer.
// - Multifunction pin configurable as active-low alert output for limit events.
package smbus_pkg;

   localparam logic [6:0] SLAVE_ADDR      = 7'h2E;
   localparam logic [7:0] WRITE_ADDR_BYTE = 8'h5C;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [1:0] MAX_WRITE_BYTES = 2'h2;
   localparam logic [7:0] POINTER_RESET   = 8'h00;
   localparam logic [1:0] SYNC_RESET      = 2'h3;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_ADDR   = 7'h02,
      ST_ACK    = 7'h04,
      ST_WDATA  = 7'h08,
      ST_RDATA  = 7'h10,
      ST_RACK   = 7'h20,
      ST_IGNORE = 7'h40
   } state_type;

endpackage

// File: verilog/pin_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter int         WIDTH = 2,
   parameter logic [1:0] INIT  = 2'h3
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic [1:0] stage_r;
         // Bus lines idle high, so reset to high avoids a false start
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               stage_r <= INIT;
            end else begin
               stage_r <= {stage_r[0], async_in[i]};
            end
         end
         assign sync_out[i] = stage_r[1];
      end
   endgenerate

endmodule

// File: verilog/smbus_slave_register_pointer.sv
// Management bus slave with register pointer, write strobe and alert pin
`timescale 1ns/100ps
module smbus_slave_register_pointer (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wr_data,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   input  wire logic [7:0] reg_rd_data,
   input  wire logic       alert_enable,
   input  wire logic       alert_req,
   output logic            alert_out,
   output logic            alert_oe
);

   smbus_pkg::state_type state_r;
   logic [1:0]           line_s;
   logic                 scl_s;
   logic                 sda_s;
   logic                 scl_q_r;
   logic                 sda_q_r;
   logic [3:0]           bit_cnt_r;
   logic [7:0]           shift_r;
   logic                 rw_r;
   logic [1:0]           byte_idx_r;
   logic [7:0]           pointer_r;
   logic [7:0]           wr_data_r;
   logic                 wr_en_r;
   logic                 rd_en_r;
   logic                 sda_oe_r;
   logic                 sda_out_r;
   logic                 alert_oe_r;
   logic                 alert_out_r;
   logic                 scl_rise;
   logic                 scl_fall;
   logic                 start_det;
   logic                 stop_det;
   logic                 byte_full;
   logic                 addr_match;
   logic                 addr_end;
   logic                 wbyte_end;
   logic                 wbyte_ok;

   pin_sync #(
      .WIDTH (2),
      .INIT  (smbus_pkg::SYNC_RESET)
   ) u_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in ({scl_in, sda_in}),
      .sync_out (line_s)
   );

   assign scl_s = line_s[1];
   assign sda_s = line_s[0];

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_q_r;
   assign scl_fall   = ~scl_s & scl_q_r;
   assign start_det  = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_det   = scl_s & scl_q_r & ~sda_q_r & sda_s;
   assign byte_full  = (bit_cnt_r == smbus_pkg::BITS_PER_BYTE);
   assign addr_match = (shift_r[7:1] == smbus_pkg::SLAVE_ADDR);
   assign addr_end   = (state_r == smbus_pkg::ST_ADDR) & scl_fall & byte_full;
   assign wbyte_end  = (state_r == smbus_pkg::ST_WDATA) & scl_fall & byte_full;
   assign wbyte_ok   = (byte_idx_r < smbus_pkg::MAX_WRITE_BYTES);

   // Sequencer; start and stop outrank bit events so a repeated start always restarts
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r    <= smbus_pkg::ST_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         rw_r       <= 1'b0;
         byte_idx_r <= 2'h0;
      end else if (start_det) begin
         state_r    <= smbus_pkg::ST_ADDR;
         bit_cnt_r  <= 4'h0;
         byte_idx_r <= 2'h0;
      end else if (stop_det) begin
         state_r <= smbus_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            smbus_pkg::ST_ADDR, smbus_pkg::ST_WDATA: begin
               if (scl_rise && !byte_full) begin
                  shift_r   <= {shift_r[6:0], sda_s};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (addr_end) begin
                  rw_r    <= shift_r[0];
                  state_r <= addr_match ? smbus_pkg::ST_ACK : smbus_pkg::ST_IGNORE;
               end else if (wbyte_end) begin
                  byte_idx_r <= byte_idx_r + 2'h1;
                  state_r <= wbyte_ok ? smbus_pkg::ST_ACK : smbus_pkg::ST_IGNORE;
               end
            end
            smbus_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (rw_r) begin
                     state_r   <= smbus_pkg::ST_RDATA;
                     shift_r   <= reg_rd_data;
                     bit_cnt_r <= 4'h1;
                  end else begin
                     state_r   <= smbus_pkg::ST_WDATA;
                     bit_cnt_r <= 4'h0;
                  end
               end
            end
            smbus_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (byte_full) begin
                     state_r <= smbus_pkg::ST_RACK;
                  end else begin
                     shift_r   <= {shift_r[6:0], 1'b0};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            smbus_pkg::ST_RACK: begin
               // Only one byte per read; any further clocks see a released line
               if (scl_fall) begin
                  state_r <= smbus_pkg::ST_IGNORE;
               end
            end
            smbus_pkg::ST_IDLE, smbus_pkg::ST_IGNORE: begin
               state_r <= state_r;
            end
            default: begin
               state_r <= smbus_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Data line drive: only pulls low for acknowledge or read data
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sda_oe_r  <= 1'b0;
         sda_out_r <= 1'b0;
      end else begin
         sda_out_r <= 1'b0;
         if (start_det || stop_det) begin
            sda_oe_r <= 1'b0;
         end else if (addr_end) begin
            sda_oe_r <= addr_match;
         end else if (wbyte_end) begin
            sda_oe_r <= wbyte_ok;
         end else if (scl_fall) begin
            unique case (state_r)
               smbus_pkg::ST_ACK: begin
                  sda_oe_r <= rw_r & ~reg_rd_data[7];
               end
               smbus_pkg::ST_RDATA: begin
                  sda_oe_r <= ~byte_full & ~shift_r[6];
               end
               default: begin
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Pointer survives stops and reads; only a first write byte replaces it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pointer_r <= smbus_pkg::POINTER_RESET;
      end else if (!start_det && !stop_det && wbyte_end && byte_idx_r == 2'h0) begin
         pointer_r <= shift_r;
      end
   end

   // Register strobes toward the register file
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_en_r   <= 1'b0;
         wr_data_r <= 8'h00;
         rd_en_r   <= 1'b0;
      end else begin
         wr_en_r <= !start_det && !stop_det && wbyte_end && byte_idx_r == 2'h1;
         rd_en_r <= !start_det && !stop_det && addr_end && addr_match && shift_r[0];
         if (wbyte_end) begin
            wr_data_r <= shift_r;
         end
      end
   end

   // Alert pin: open drain, pulled low while enabled and a limit event is pending
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alert_oe_r  <= 1'b0;
         alert_out_r <= 1'b0;
      end else begin
         alert_out_r <= 1'b0;
         alert_oe_r  <= alert_enable & alert_req;
      end
   end

   assign sda_out     = sda_out_r;
   assign sda_oe      = sda_oe_r;
   assign reg_addr    = pointer_r;
   assign reg_wr_data = wr_data_r;
   assign reg_wr_en   = wr_en_r;
   assign reg_rd_en   = rd_en_r;
   assign alert_out   = alert_out_r;
   assign alert_oe    = alert_oe_r;

   AST_ADDR_ACK: assert property (@(posedge clock) disable iff (!reset_n)
      addr_end && addr_match && !start_det && !stop_det |=> sda_oe_r ##1 sda_oe_r[*1])
      else $error("Matching address not acknowledged");

   AST_ADDR_NACK: assert property (@(posedge clock) disable iff (!reset_n)
      addr_end && !addr_match && !start_det && !stop_det
      |=> (!sda_oe_r && state_r == smbus_pkg::ST_IGNORE))
      else $error("Foreign address acknowledged");

   AST_PTR_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
      wbyte_end && byte_idx_r == 2'h0 && !start_det && !stop_det
      |=> pointer_r == $past(shift_r) && !wr_en_r)
      else $error("First write byte did not load pointer");

   AST_WR_STROBE: assert property (@(posedge clock) disable iff (!reset_n)
      wr_en_r |-> $past(byte_idx_r) == 2'h1 && reg_wr_data == $past(shift_r))
      else $error("Write strobe without second byte");

   AST_THIRD_NACK: assert property (@(posedge clock) disable iff (!reset_n)
      wbyte_end && byte_idx_r == 2'h2 && !start_det && !stop_det |=> !sda_oe_r)
      else $error("Third write byte acknowledged");

   AST_PTR_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
      stop_det |=> $stable(pointer_r) ##1 $stable(pointer_r))
      else $error("Pointer changed across stop");

   AST_RESTART: assert property (@(posedge clock) disable iff (!reset_n)
      start_det |=> state_r == smbus_pkg::ST_ADDR && bit_cnt_r == 4'h0 && !sda_oe_r)
      else $error("Repeated start not taken");

   AST_READ_MSB: assert property (@(posedge clock) disable iff (!reset_n)
      state_r == smbus_pkg::ST_ACK && scl_fall && rw_r && !start_det && !stop_det
      |=> sda_oe_r == !$past(reg_rd_data[7]) && state_r == smbus_pkg::ST_RDATA)
      else $error("Read data MSB wrong");

   AST_ONE_READ: assert property (@(posedge clock) disable iff (!reset_n)
      state_r == smbus_pkg::ST_RACK && scl_fall && !start_det && !stop_det
      |=> state_r == smbus_pkg::ST_IGNORE && !sda_oe_r)
      else $error("More than one read byte");

   AST_SLAVE_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
      sda_oe_r |-> (state_r == smbus_pkg::ST_ACK || state_r == smbus_pkg::ST_RDATA
                    || state_r == smbus_pkg::ST_RACK) && !sda_out)
      else $error("Data line driven outside slave slots");

   AST_ALERT: assert property (@(posedge clock) disable iff (!reset_n)
      alert_enable && alert_req |=> alert_oe && !alert_out)
      else $error("Alert not asserted");

endmodule

// File: dv/smbus_master_model.sv
// Bus master model driving the clock and data pins of the slave
`timescale 1ns/100ps
module smbus_master_model (
   input  wire logic clock,
   input  wire logic sda_line,
   output logic      scl_pin,
   output logic      sda_low
);
   initial begin
      scl_pin = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Start or repeated start: data falls while clock high
   task automatic start_cond();
      sda_low <= 1'b0;
      wait_clk(4);
      scl_pin <= 1'b1;
      wait_clk(8);
      sda_low <= 1'b1;
      wait_clk(8);
      scl_pin <= 1'b0;
      wait_clk(4);
   endtask
   // Stop: data low in the low phase, released during the high phase
   task automatic stop_cond();
      sda_low <= 1'b1;
      wait_clk(4);
      scl_pin <= 1'b1;
      wait_clk(8);
      sda_low <= 1'b0;
      wait_clk(8);
   endtask
   // Data set only in the low phase, so no false start or stop is made
   task automatic bit_io(input logic b, output logic r);
      sda_low <= ~b;
      wait_clk(4);
      scl_pin <= 1'b1;
      wait_clk(4);
      r = sda_line;
      wait_clk(4);
      scl_pin <= 1'b0;
      wait_clk(4);
   endtask
   task automatic byte_out(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // The single read byte is always not-acknowledged
   task automatic byte_in(output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(1'b1, r);
   endtask
endmodule

// File: dv/tb_top.sv
// Testbench for the management bus slave with register pointer
`timescale 1ns/100ps
module tb_top;
   logic       clock;
   logic       reset_n;
   logic       scl_pin;
   logic       sda_low;
   logic       sda_line;
   logic       sda_out;
   logic       sda_oe;
   logic [7:0] reg_addr;
   logic [7:0] reg_wr_data;
   logic [7:0] reg_rd_data;
   logic       reg_wr_en;
   logic       reg_rd_en;
   logic       alert_enable;
   logic       alert_req;
   logic       alert_out;
   logic       alert_oe;
   logic [7:0] regs [256];
   int         err_count = 0;
   int         num_checks = 0;
   int         wr_count = 0;
   int         rd_count = 0;
   int         cycles = 0;

   initial clock = 1'b0;
   always #10 clock = ~clock;
   // Pulled-up open-drain wire
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

   smbus_slave_register_pointer uut (.clock(clock), .reset_n(reset_n), .scl_in(scl_pin),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_rd_data(reg_rd_data), .alert_enable(alert_enable), .alert_req(alert_req),
      .alert_out(alert_out), .alert_oe(alert_oe));
   smbus_master_model m (.clock(clock), .sda_line(sda_line), .scl_pin(scl_pin),
      .sda_low(sda_low));

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Register file behind the slave; also counts write strobes
   always @(posedge clock) begin
      reg_rd_data <= regs[reg_addr];
      if (reg_wr_en === 1'b1) begin
         regs[reg_addr] <= reg_wr_data;
         wr_count <= wr_count + 1;
      end
      // Read strobes are counted so the pulse is judged against the scenarios
      if (reg_rd_en === 1'b1) begin
         rd_count <= rd_count + 1;
      end
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string s);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp, input string s);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %b expected %b", $time, s, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] v, input logic exp_ack);
      logic a;
      m.byte_out(v, a);
      check_bit(a, exp_ack, "ack");
   endtask
   task automatic recv(input logic [7:0] exp);
      logic [7:0] v;
      m.byte_in(v);
      check_byte(v, exp, "read data");
   endtask

   task automatic t_write_byte();
      m.start_cond();
      send(8'h5C, 1'b1);
      send(8'h41, 1'b1);
      send(8'hA5, 1'b1);
      m.stop_cond();
      check_byte(reg_addr, 8'h41, "pointer");
      check_byte(regs[8'h41], 8'hA5, "stored");
      check_byte(8'(wr_count), 8'h01, "writes");
   endtask
   task automatic t_send_then_read();
      m.start_cond();
      send(8'h5C, 1'b1);
      send(8'h07, 1'b1);
      m.start_cond();
      send(8'h5D, 1'b1);
      recv(8'hF8);
      m.stop_cond();
      check_byte(8'(wr_count), 8'h01, "writes");
      m.start_cond();
      send(8'h5D, 1'b1);
      recv(8'hF8);
      m.stop_cond();
      check_byte(8'(rd_count), 8'h02, "reads");
   endtask
   // Third write byte is refused; data lands at the new pointer only
   task automatic t_third_byte();
      m.start_cond();
      send(8'h5C, 1'b1);
      send(8'h20, 1'b1);
      send(8'h3C, 1'b1);
      send(8'h99, 1'b0);
      m.stop_cond();
      check_byte(regs[8'h20], 8'h3C, "stored");
      check_byte(regs[8'h07], 8'hF8, "untouched");
      check_byte(reg_addr, 8'h20, "pointer");
      check_byte(8'(wr_count), 8'h02, "writes");
   endtask
   task automatic t_bad_addr();
      logic [7:0] bad [3];
      bad = '{8'h5E, 8'h1C, 8'hDD};
      foreach (bad[i]) begin
         m.start_cond();
         send(bad[i], 1'b0);
         send(8'h11, 1'b0);
         m.stop_cond();
      end
      check_byte(reg_addr, 8'h20, "pointer");
      m.start_cond();
      send(8'h5D, 1'b1);
      recv(8'h3C);
      m.stop_cond();
      check_byte(8'(rd_count), 8'h03, "reads");
   endtask
   task automatic t_alert();
      for (int i = 0; i < 4; i++) begin
         alert_enable <= i[1];
         alert_req <= i[0];
         repeat (3) @(posedge clock);
         check_bit(alert_oe, i[1] & i[0], "alert drive");
         check_bit(alert_out, 1'b0, "alert level");
      end
   endtask

   initial begin
      reset_n = 1'b0;
      alert_enable = 1'b0;
      alert_req = 1'b0;
      for (int i = 0; i < 256; i++) regs[i] = ~8'(i);
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      check_bit(sda_oe, 1'b0, "idle release");
      check_byte(reg_addr, 8'h00, "reset pointer");
      t_write_byte();
      t_send_then_read();
      t_third_byte();
      t_bad_addr();
      t_alert();
      print_verdict();
   end
endmodule
